//--- verilog/shic_standby_ctrl.sv
// Standby controller: halt and idle-one entry, release and clock gating
//
// How it works
// - Halt instruction gates processor clock and, per source, timer clocks.
// - Pending request at halt entry exits immediately.
// - Halt ends on nonmaskable, pin, peripheral, reset.
// - Any request wakes; lower priority stays pending.
// - Higher priority request wakes and is acknowledged.
// - Nonmaskable branches; maskable depends on enable state.
// - Reset release performs ordinary reset sequence.
// - Halt keeps oscillators, peripherals, event timer rules.
// - Watch timer in halt follows its source.
// - Halt holds ports, registers, flags, RAM.
// - Select bits 00 plus trigger enters idle-one.
// - Select bits honoured only while trigger set.
// - Idle-one stops processor and main-clock peripherals.
// - Secondary clock peripherals run; RAM kept.
// - Idle-one exit needs no stabilisation wait.
// - Pending request at idle-one entry exits immediately.
// - Idle-one ends on nonmaskable, pin, idle-capable peripheral, reset.
// - Wake mask bits block idle-one release.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module shic_standby_ctrl
   import shic_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Register port
   input wire logic [shic_pkg::ADDR_W-1:0] addr_in,
   input wire logic [shic_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [shic_pkg::DATA_W-1:0] rdata_out,
   // Processor and interrupt controller
   input wire logic halt_exec_in,
   input wire logic nmi_pin_in,
   input wire logic watchdog_nonmask_irq_in,
   input wire logic [shic_pkg::NPIN-1:0] ext_pin_irq_in,
   input wire logic periph_irq_in,
   input wire logic periph_idle_irq_in,
   input wire logic [shic_pkg::PRIO_W-1:0] req_prio_in,
   input wire logic svc_active_in,
   input wire logic [shic_pkg::PRIO_W-1:0] svc_prio_in,
   input wire logic irq_enabled_state_in,
   input wire logic [shic_pkg::NRST-1:0] rst_src_in,
   // Results
   output logic cpu_clk_en_out,
   output logic periph_clk_en_out,
   output logic osc_pll_flash_en_out,
   output logic event_timer_clk_en_out,
   output logic watch_timer_clk_en_out,
   output logic state_hold_out,
   output logic wake_branch_out,
   output logic wake_resume_out,
   output logic sys_reset_out,
   output logic [1:0] state_out
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [1:0] mode_r;
   logic trig_r;
   logic maskable_m_r;
   logic nonmask0_m_r;
   logic nonmask1_m_r;
   logic [2:0] cfg_r;
   shic_state_t state_r;
   shic_cause_t cause_r;
   logic deep_r;
   logic [DATA_W-1:0] rdata_r;
   logic cpu_en_r;
   logic periph_en_r;
   logic osc_en_r;
   logic evt_en_r;
   logic watch_en_r;
   logic hold_r;
   logic branch_r;
   logic resume_r;
   logic sysrst_r;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic wr_mode;
   wire logic wr_ctrl;
   wire logic wr_cfg;
   wire logic any_rst;
   wire logic in_halt;
   wire logic in_idle;
   wire logic wake;
   wire logic nonmask;
   wire logic branch;
   wire logic trig_wr;
   wire logic idle_req;
   wire logic deep_req;
   wire logic halt_req;
   wire logic sec_pres;
   wire logic evt_sec;
   wire logic watch_baud;

   // Address decode for writes
   assign wr_mode = wr_in & (addr_in == MODE_REG_OFS);
   assign wr_ctrl = wr_in & (addr_in == CTRL_REG_OFS);
   assign wr_cfg = wr_in & (addr_in == CFG_REG_OFS);

   assign any_rst = |rst_src_in;
   assign in_halt = (state_r == ST_HALT);
   assign in_idle = (state_r == ST_IDLE_ONE);
   assign sec_pres = cfg_r[SEC_PRES_POS];
   assign evt_sec = cfg_r[EVT_SEC_POS];
   assign watch_baud = cfg_r[WATCH_BAUD_POS];

   // Select bits only count in the trigger write itself
   assign trig_wr = wr_ctrl & wdata_in[TRIG_POS];
   assign idle_req = trig_wr & (mode_r == SEL_IDLE_ONE);
   assign deep_req = trig_wr & (mode_r != SEL_IDLE_ONE);
   assign halt_req = halt_exec_in;

   // ----------------------------------------------------------------
   // Wake evaluation, every cycle
   // ----------------------------------------------------------------
   shic_wake_eval u_wake (
      .in_halt_in(in_halt),
      .in_idle_in(in_idle),
      .nmi_pin_in(nmi_pin_in),
      .watchdog_nonmask_irq_in(watchdog_nonmask_irq_in),
      .ext_pin_irq_in(ext_pin_irq_in),
      .periph_irq_in(periph_irq_in),
      .periph_idle_irq_in(periph_idle_irq_in),
      .nonmask0_wake_mask_in(nonmask0_m_r),
      .nonmask1_wake_mask_in(nonmask1_m_r),
      .maskable_wake_mask_in(maskable_m_r),
      .req_prio_in(req_prio_in),
      .svc_active_in(svc_active_in),
      .svc_prio_in(svc_prio_in),
      .irq_enabled_state_in(irq_enabled_state_in),
      .wake_out(wake),
      .nonmask_out(nonmask),
      .branch_out(branch)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   shic_state_t state_nxt;

   // Entry in the cycle of the request; a pending source is seen
   // one cycle later, so the state is entered and then left
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_NORMAL: begin
            if (halt_req) begin
               state_nxt = ST_HALT;
            end else if (idle_req) begin
               state_nxt = ST_IDLE_ONE;
            end
         end
         ST_HALT, ST_IDLE_ONE: begin
            if (wake) begin
               state_nxt = ST_NORMAL;
            end
         end
         default: begin
            state_nxt = ST_NORMAL;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Clock rules per state
   // ----------------------------------------------------------------
   // Event timer: halt stops it only on an absent secondary source;
   // idle keeps it only when it counts the secondary clock
   function automatic logic evt_rule(input shic_state_t st,
                                     input logic pres,
                                     input logic sec);
      if (st == ST_HALT) begin
         evt_rule = pres | ~sec;
      end else if (st == ST_IDLE_ONE) begin
         evt_rule = pres & sec;
      end else begin
         evt_rule = 1'b1;
      end
   endfunction

   // Watch timer: same rule in halt and idle
   function automatic logic watch_rule(input shic_state_t st,
                                       input logic pres,
                                       input logic baud);
      if (st == ST_NORMAL) begin
         watch_rule = 1'b1;
      end else begin
         watch_rule = pres | baud;
      end
   endfunction

   wire logic cpu_en_nxt;
   wire logic periph_en_nxt;
   wire logic evt_en_nxt;
   wire logic watch_en_nxt;
   wire logic leaving;

   // Enables follow the next state so they move with the state
   assign cpu_en_nxt = (state_nxt == ST_NORMAL);
   assign periph_en_nxt = (state_nxt != ST_IDLE_ONE);
   assign evt_en_nxt = evt_rule(state_nxt, sec_pres, evt_sec);
   assign watch_en_nxt = watch_rule(state_nxt, sec_pres, watch_baud);
   assign leaving = (in_halt | in_idle) & wake;

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   wire logic [DATA_W-1:0] mode_view;
   wire logic [DATA_W-1:0] ctrl_view;
   wire logic [DATA_W-1:0] cfg_view;
   wire logic [DATA_W-1:0] stat_view;
   wire logic [DATA_W-1:0] rd_sel;

   assign mode_view = {6'h00, mode_r};
   assign ctrl_view = {1'b0, nonmask1_m_r, nonmask0_m_r, maskable_m_r,
                       2'h0, trig_r, 1'b0};
   assign cfg_view = {5'h00, cfg_r};
   assign stat_view = {3'h0, deep_r, cause_r, state_r};

   // Unmapped addresses read as zero
   assign rd_sel = (addr_in == MODE_REG_OFS) ? mode_view :
                   (addr_in == CTRL_REG_OFS) ? ctrl_view :
                   (addr_in == CFG_REG_OFS) ? cfg_view :
                   (addr_in == STAT_REG_OFS) ? stat_view : 8'h00;

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   // A reset source returns the mode, control and configuration registers to their reset values
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mode_r <= MODE_RST;
         cfg_r <= CFG_RST;
         maskable_m_r <= CTRL_RST[MASKABLE_M_POS-4];
         nonmask0_m_r <= CTRL_RST[NONMASK0_M_POS-4];
         nonmask1_m_r <= CTRL_RST[NONMASK1_M_POS-4];
      end else if (any_rst) begin
         mode_r <= MODE_RST;
         cfg_r <= CFG_RST;
         maskable_m_r <= CTRL_RST[MASKABLE_M_POS-4];
         nonmask0_m_r <= CTRL_RST[NONMASK0_M_POS-4];
         nonmask1_m_r <= CTRL_RST[NONMASK1_M_POS-4];
      end else begin
         if (wr_mode) begin
            mode_r <= wdata_in[SEL_HI_POS:SEL_LO_POS];
         end
         if (wr_cfg) begin
            cfg_r <= wdata_in[WATCH_BAUD_POS:SEC_PRES_POS];
         end
         if (wr_ctrl) begin
            maskable_m_r <= wdata_in[MASKABLE_M_POS];
            nonmask0_m_r <= wdata_in[NONMASK0_M_POS];
            nonmask1_m_r <= wdata_in[NONMASK1_M_POS];
         end
      end
   end

   // Trigger stays set through idle and drops on release; deeper
   // modes are not served here and the trigger is dropped at once
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         trig_r <= 1'b0;
         deep_r <= 1'b0;
      end else if (any_rst) begin
         trig_r <= 1'b0;
         deep_r <= 1'b0;
      end else if (in_idle & wake) begin
         trig_r <= 1'b0;
      end else if (wr_ctrl) begin
         trig_r <= idle_req & (state_r == ST_NORMAL) & ~halt_req;
         deep_r <= deep_req;
      end
   end

   // ----------------------------------------------------------------
   // State and release cause
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= ST_NORMAL;
         cause_r <= CAUSE_NONE;
      end else if (any_rst) begin
         state_r <= ST_NORMAL;
         cause_r <= (state_r == ST_NORMAL) ? CAUSE_NONE : CAUSE_RESET;
      end else begin
         state_r <= state_nxt;
         if (leaving) begin
            cause_r <= nonmask ? CAUSE_NONMASK : CAUSE_MASKABLE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock enables and hold
   // ----------------------------------------------------------------
   // Oscillators, PLL and flash never stop in these two states
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cpu_en_r <= 1'b1;
         periph_en_r <= 1'b1;
         osc_en_r <= 1'b1;
         evt_en_r <= 1'b1;
         watch_en_r <= 1'b1;
         hold_r <= 1'b0;
      end else if (any_rst) begin
         cpu_en_r <= 1'b1;
         periph_en_r <= 1'b1;
         osc_en_r <= 1'b1;
         evt_en_r <= 1'b1;
         watch_en_r <= 1'b1;
         hold_r <= 1'b0;
      end else begin
         cpu_en_r <= cpu_en_nxt;
         periph_en_r <= periph_en_nxt;
         osc_en_r <= 1'b1;
         evt_en_r <= evt_en_nxt;
         watch_en_r <= watch_en_nxt;
         hold_r <= (state_nxt != ST_NORMAL);
      end
   end

   // ----------------------------------------------------------------
   // Release pulses, reset request and read data
   // ----------------------------------------------------------------
   // A request that is not acknowledged stays pending in the
   // interrupt controller; only resume is signalled for it
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         branch_r <= 1'b0;
         resume_r <= 1'b0;
         sysrst_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         branch_r <= leaving & branch & ~any_rst;
         resume_r <= leaving & ~branch & ~any_rst;
         sysrst_r <= any_rst;
         rdata_r <= rd_in ? rd_sel : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata_out = rdata_r;
   assign cpu_clk_en_out = cpu_en_r;
   assign periph_clk_en_out = periph_en_r;
   assign osc_pll_flash_en_out = osc_en_r;
   assign event_timer_clk_en_out = evt_en_r;
   assign watch_timer_clk_en_out = watch_en_r;
   assign state_hold_out = hold_r;
   assign wake_branch_out = branch_r;
   assign wake_resume_out = resume_r;
   assign sys_reset_out = sysrst_r;
   assign state_out = state_r;

endmodule
`default_nettype wire

//--- verilog/shic_pkg.sv
// Constants and types shared by the standby halt and idle controller
package shic_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int PRIO_W = 3;
   localparam int NPIN = 8;
   localparam int NRST = 5;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_REG_OFS = 4'h0;
   localparam logic [3:0] CTRL_REG_OFS = 4'h4;
   localparam logic [3:0] CFG_REG_OFS = 4'h8;
   localparam logic [3:0] STAT_REG_OFS = 4'hC;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SEL_LO_POS = 0;
   localparam int SEL_HI_POS = 1;
   localparam int TRIG_POS = 1;
   localparam int MASKABLE_M_POS = 4;
   localparam int NONMASK0_M_POS = 5;
   localparam int NONMASK1_M_POS = 6;
   localparam int SEC_PRES_POS = 0;
   localparam int EVT_SEC_POS = 1;
   localparam int WATCH_BAUD_POS = 2;
   localparam int STAT_STATE_POS = 0;
   localparam int STAT_CAUSE_POS = 2;
   localparam int STAT_DEEP_POS = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [2:0] CFG_RST = 3'h0;

   // ----------------------------------------------------------------
   // Codes
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_IDLE_ONE = 2'h0;

   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_HALT = 2'b01,
      ST_IDLE_ONE = 2'b10
   } shic_state_t;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'b00,
      CAUSE_NONMASK = 2'b01,
      CAUSE_MASKABLE = 2'b10,
      CAUSE_RESET = 2'b11
   } shic_cause_t;

endpackage

//--- verilog/shic_wake_eval.sv
// Wake source combiner and priority judge for the standby controller
`timescale 1ns/1ps
`default_nettype none
module shic_wake_eval
   import shic_pkg::*;
(
   input wire logic in_halt_in,
   input wire logic in_idle_in,
   input wire logic nmi_pin_in,
   input wire logic watchdog_nonmask_irq_in,
   input wire logic [shic_pkg::NPIN-1:0] ext_pin_irq_in,
   input wire logic periph_irq_in,
   input wire logic periph_idle_irq_in,
   input wire logic nonmask0_wake_mask_in,
   input wire logic nonmask1_wake_mask_in,
   input wire logic maskable_wake_mask_in,
   input wire logic [shic_pkg::PRIO_W-1:0] req_prio_in,
   input wire logic svc_active_in,
   input wire logic [shic_pkg::PRIO_W-1:0] svc_prio_in,
   input wire logic irq_enabled_state_in,
   output logic wake_out,
   output logic nonmask_out,
   output logic branch_out
);

   // ----------------------------------------------------------------
   // Source gating per state
   // ----------------------------------------------------------------
   wire logic any_pin;
   wire logic nm_halt;
   wire logic nm_idle;
   wire logic mk_halt;
   wire logic mk_idle;
   wire logic higher;
   wire logic mask_wake;

   // Masks only apply in idle; halt sees every source, masked or not
   assign any_pin = |ext_pin_irq_in;
   assign nm_halt = nmi_pin_in | watchdog_nonmask_irq_in;
   assign nm_idle = (nmi_pin_in & ~nonmask0_wake_mask_in)
                  | (watchdog_nonmask_irq_in & ~nonmask1_wake_mask_in);
   assign mk_halt = any_pin | periph_irq_in;
   assign mk_idle = (any_pin | periph_idle_irq_in)
                  & ~maskable_wake_mask_in;

   // Any priority wakes; priority only decides acknowledgement
   assign nonmask_out = (in_halt_in & nm_halt) | (in_idle_in & nm_idle);
   assign mask_wake = (in_halt_in & mk_halt) | (in_idle_in & mk_idle);
   assign wake_out = nonmask_out | mask_wake;

   // Lower code means higher priority
   assign higher = ~svc_active_in | (req_prio_in < svc_prio_in);

   // Nonmaskable always branches; maskable needs enable and rank
   assign branch_out = nonmask_out
                     | (mask_wake & irq_enabled_state_in & higher);

endmodule
`default_nettype wire

//--- bench/shic_checker.sv
// Assertion checker for the standby halt and idle controller
`timescale 1ns/1ps
`default_nettype none
module shic_checker
   import shic_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic halt_exec_in,
   input wire logic nmi_pin_in,
   input wire logic watchdog_nonmask_irq_in,
   input wire logic [shic_pkg::NPIN-1:0] ext_pin_irq_in,
   input wire logic periph_irq_in,
   input wire logic [shic_pkg::NRST-1:0] rst_src_in,
   input wire logic cpu_clk_en_out,
   input wire logic periph_clk_en_out,
   input wire logic osc_pll_flash_en_out,
   input wire logic state_hold_out,
   input wire logic wake_branch_out,
   input wire logic wake_resume_out,
   input wire logic sys_reset_out,
   input wire logic [1:0] state_out
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // Halt release sources; the wake masks never act in halt
   wire halt_src = nmi_pin_in | watchdog_nonmask_irq_in |
      (|ext_pin_irq_in) | periph_irq_in;
   wire rst_any = |rst_src_in;

   a_halt_entry: assert property (state_out == 2'h0 && halt_exec_in &&
      !rst_any |=> state_out == 2'h1 && !cpu_clk_en_out)
      else $error("halt entry missed");
   a_halt_hold: assert property (state_out == 2'h1 |-> state_hold_out &&
      !cpu_clk_en_out && periph_clk_en_out && osc_pll_flash_en_out)
      else $error("halt gating wrong");
   a_idle_gate: assert property (state_out == 2'h2 |-> state_hold_out &&
      !cpu_clk_en_out && !periph_clk_en_out && osc_pll_flash_en_out)
      else $error("idle gating wrong");
   a_halt_wake: assert property (state_out == 2'h1 && halt_src && !rst_any
      |=> state_out == 2'h0 && cpu_clk_en_out &&
      (wake_branch_out ^ wake_resume_out))
      else $error("halt release missed");
   a_nmi_branch: assert property (state_out == 2'h1 && nmi_pin_in &&
      !rst_any |=> wake_branch_out)
      else $error("nonmaskable did not branch");
   a_halt_stays: assert property (state_out == 2'h1 && !halt_src &&
      !rst_any |=> state_out == 2'h1)
      else $error("halt left without cause");
   a_reset_seq: assert property (rst_any |=> sys_reset_out &&
      state_out == 2'h0 && cpu_clk_en_out && !wake_branch_out &&
      !wake_resume_out)
      else $error("reset sequence wrong");
   a_pulse_cause: assert property ((wake_branch_out || wake_resume_out)
      |-> $past(state_out) != 2'h0 && state_out == 2'h0 ##1
      !wake_branch_out && !wake_resume_out)
      else $error("release pulse wrong");
   c_halt_br: cover property (state_out == 2'h1 ##1 wake_branch_out);
   c_idle_out: cover property (state_out == 2'h2 ##1 state_out == 2'h0);
   c_resume: cover property (wake_resume_out);
   c_sysrst: cover property (sys_reset_out);
endmodule

bind shic_standby_ctrl shic_checker chk_u (.clk_in, .rst_b_in,
   .halt_exec_in, .nmi_pin_in, .watchdog_nonmask_irq_in, .ext_pin_irq_in,
   .periph_irq_in, .rst_src_in, .cpu_clk_en_out, .periph_clk_en_out,
   .osc_pll_flash_en_out, .state_hold_out, .wake_branch_out,
   .wake_resume_out, .sys_reset_out, .state_out);
`default_nettype wire

//--- bench/shic_cpu_model.sv
// Processor side model: halt issue with the no-op shadow after it
`timescale 1ns/1ps
`default_nettype none
module shic_cpu_model (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic halt_req_in,
   input wire logic ctrl_store_in,
   output logic halt_exec_out,
   output logic shadow_out
);
   logic [2:0] quiet_r;
   // Five no-op slots follow a halt or a control store; nothing issues
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         quiet_r <= 3'h0;
      end else if (halt_exec_out || ctrl_store_in) begin
         quiet_r <= 3'h5;
      end else if (quiet_r != 3'h0) begin
         quiet_r <= quiet_r - 3'h1;
      end
   end
   assign shadow_out = (quiet_r != 3'h0);
   assign halt_exec_out = halt_req_in && !shadow_out;
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the standby halt and idle controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import shic_pkg::*;
   logic clk_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, ext = 8'h00, rdata, v;
   logic nmi = 1'b0, wdt = 1'b0, pirq = 1'b0, pidle = 1'b0, svc = 1'b0;
   logic en = 1'b1, hreq = 1'b0, store = 1'b0;
   logic [2:0] rprio = 3'h0, sprio = 3'h0;
   logic [4:0] rsrc = 5'h00;
   logic halt, shadow, cpu_en, per_en, osc_en, evt_en, wat_en, hold;
   logic br, rs, sysrst;
   logic [1:0] st;
   logic [9:0] pt [5] = '{10'b0_1_010_101_1_0, 10'b0_1_010_001_1_1,
      10'b0_0_000_000_0_0, 10'b0_0_000_011_1_1, 10'b1_1_000_111_0_1};
   int n_mismatch = 0, cmp_count = 0;

   always #2 clk_in = ~clk_in;
   shic_cpu_model mdl_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .halt_req_in(hreq), .ctrl_store_in(store), .halt_exec_out(halt),
      .shadow_out(shadow));
   shic_standby_ctrl dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .halt_exec_in(halt), .nmi_pin_in(nmi),
      .watchdog_nonmask_irq_in(wdt), .ext_pin_irq_in(ext),
      .periph_irq_in(pirq), .periph_idle_irq_in(pidle),
      .req_prio_in(rprio), .svc_active_in(svc), .svc_prio_in(sprio),
      .irq_enabled_state_in(en), .rst_src_in(rsrc),
      .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
      .osc_pll_flash_en_out(osc_en), .event_timer_clk_en_out(evt_en),
      .watch_timer_clk_en_out(wat_en), .state_hold_out(hold),
      .wake_branch_out(br), .wake_resume_out(rs), .sys_reset_out(sysrst),
      .state_out(st));

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Bounded wait for the no-op shadow so the model never drops a request
   task automatic gap;
      for (int i = 0; i < 8 && shadow !== 1'b0; i++) begin
         @(posedge clk_in);
         #1;
      end
      if (shadow !== 1'b0) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      gap();
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      store <= (a == CTRL_REG_OFS);
      @(posedge clk_in);
      wr <= 1'b0;
      store <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic do_halt;
      gap();
      @(posedge clk_in);
      hreq <= 1'b1;
      @(posedge clk_in);
      hreq <= 1'b0;
      #1;
   endtask
   // Sources, one bit each: nmi, ext pin, idle periph, watchdog, periph
   task automatic wake(input logic [4:0] k);
      @(posedge clk_in);
      {pirq, wdt, pidle, ext[0], nmi} <= k;
      @(posedge clk_in);
      {pirq, wdt, pidle, ext[0], nmi} <= 5'h00;
      #1;
   endtask

   initial begin
      #100us;
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      // Reset values, unmapped hole reads zero
      chk({cpu_en, per_en, osc_en, evt_en, wat_en, hold, st}, 8'hF8);
      for (int i = 0; i < 5; i++) begin
         rd_reg(i < 4 ? 4'(i * 4) : 4'h2);
         chk(v, 8'h00);
      end
      $display("test reset values done");
      // Clock enables in halt and idle for every configuration
      wr_reg(MODE_REG_OFS, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr_reg(CFG_REG_OFS, 8'(c));
         do_halt();
         chk({st, cpu_en, per_en, hold, evt_en, wat_en}, {2'h1, 3'b011,
            c[0] | !c[1], c[0] | c[2]});
         wake(5'h01);
         chk({st, cpu_en, br}, {2'h0, 2'b11});
         wr_reg(CTRL_REG_OFS, 8'h02);
         chk({st, cpu_en, per_en, hold, evt_en, wat_en}, {2'h2, 3'b001,
            c[0] & c[1], c[0] | c[2]});
         wake(5'h04);
         chk({st, cpu_en, per_en, br}, {2'h0, 3'b111});
      end
      rd_reg(STAT_REG_OFS);
      chk(v & 8'h0F, 8'h08);
      $display("test clock enables done");
      // Priority against the routine in service at halt entry
      foreach (pt[i]) begin
         svc <= pt[i][8];
         sprio <= pt[i][7:5];
         rprio <= pt[i][4:2];
         en <= pt[i][1];
         do_halt();
         wake({1'b0, pt[i][9], 1'b0, !pt[i][9], 1'b0});
         chk({st, br, rs}, {2'h0, pt[i][0], !pt[i][0]});
      end
      svc <= 1'b0;
      en <= 1'b1;
      $display("test priority done");
      // Request already pending at entry
      pirq <= 1'b1;
      do_halt();
      chk(st, 8'h01);
      @(posedge clk_in);
      #1;
      chk({st, br}, 8'h01);
      pirq <= 1'b0;
      pidle <= 1'b1;
      wr_reg(CTRL_REG_OFS, 8'h02);
      chk(st, 8'h02);
      @(posedge clk_in);
      #1;
      chk({st, br}, 8'h01);
      pidle <= 1'b0;
      $display("test pending entry done");
      // Each reset source ends halt
      for (int b = 0; b < 5; b++) begin
         do_halt();
         @(posedge clk_in);
         rsrc <= 5'(1 << b);
         @(posedge clk_in);
         rsrc <= 5'h00;
         #1;
         chk({st, sysrst, cpu_en}, 8'h03);
      end
      // Masked idle ignores all requests and ends only by reset
      wr_reg(CFG_REG_OFS, 8'h07);
      wr_reg(CTRL_REG_OFS, 8'h72);
      {wdt, nmi, pidle, pirq} <= 4'hF;
      ext <= 8'h80;
      repeat (3) @(posedge clk_in);
      #1;
      chk(st, 8'h02);
      rd_reg(CTRL_REG_OFS);
      chk(v, 8'h72);
      @(posedge clk_in);
      rsrc <= 5'h10;
      @(posedge clk_in);
      rsrc <= 5'h00;
      {wdt, nmi, pidle, pirq} <= 4'h0;
      ext <= 8'h00;
      #1;
      chk({st, sysrst}, 8'h01);
      rd_reg(STAT_REG_OFS);
      chk(v, 8'h0C);
      rd_reg(CFG_REG_OFS);
      chk(v, 8'h00);
      $display("test reset release done");
      // Deeper select codes are refused with trigger set
      for (int m = 1; m < 4; m++) begin
         wr_reg(MODE_REG_OFS, 8'(m));
         wr_reg(CTRL_REG_OFS, 8'h02);
         chk(st, 8'h00);
         rd_reg(CTRL_REG_OFS);
         chk(v, 8'h00);
         rd_reg(STAT_REG_OFS);
         chk(v & 8'h10, 8'h10);
      end
      $display("test select codes done");
      report_and_stop();
   end
endmodule
`default_nettype wire
